//--- core/interp_lane.sv
// one linear interpolator: edge accumulator plus span accumulator
`timescale 1ns/1ps
module interp_lane #(
  parameter int W = 48
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [W-1:0] origin_i,
  input wire logic [W-1:0] edge_step_i,
  input wire logic [W-1:0] span_step_i,
  input wire logic correct_i,
  input wire logic span_start_i,
  input wire logic frag_step_i,
  input wire logic line_step_i,
  output logic [W-1:0] value_o
);
  logic [W-1:0] edge_acc;
  logic [W-1:0] span_acc;
  wire [W-1:0] half_span = {span_step_i[W-1], span_step_i[W-1:1]};
  // seed from the edge value this same clock settles on, so no span lags a line
  wire [W-1:0] edge_next = load_i ? origin_i : line_step_i ? edge_acc + edge_step_i : edge_acc;
  wire [W-1:0] span_seed = correct_i ? edge_next + half_span : edge_next;

  // edge value moves once per scanline, span value once per fragment
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_acc <= '0;
      span_acc <= '0;
    end else begin
      if (load_i || line_step_i) edge_acc <= edge_next;
      if (span_start_i) span_acc <= span_seed;
      else if (frag_step_i) span_acc <= span_acc + span_step_i;
    end
  end

  assign value_o = span_acc;
endmodule : interp_lane

//--- core/tri_walk.sv
// triangle setup and edge-walking span generator with axi4-lite registers
//
// Behaviour
// - spans are walked from the main edge toward the minor edge, direction set by side.
// - colour origins and steps are 24-bit two's complement fixed point.
// - depth values are 16.32 two's complement, integer half in the upper register.
// - the depth step fraction words hold 16 bits at their top, lower bits zero; the start fraction keeps all 32.
// - scan settings persist until rewritten; zero is the shaded-triangle default.
// - with correction on, every interpolant is sampled at the fragment centre.
// - correction enable comes from the render command word per primitive.
// - the Y step sign chooses walking downward or upward.
// - trapezoids are walked directly; flat triangles are zero-length edges.
// - each scanline adds the edge slopes to the previous span ends, except the knee line, which reloads the minor end from minor_edge_x_origin.
// - colours add edge step per scanline and span step per fragment.
// - depth is interpolated like colour with its own steps.
// - the resume command carries the remaining count and starts after the first part.
`timescale 1ns/1ps
module tri_walk
  import tri_walk_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic FRAG_VALID_O,
  output frag_type FRAG_O,
  input wire logic FRAG_READY_I,
  output logic BUSY_O
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] main_edge_x_origin, main_edge_slope;
  logic [31:0] minor_edge_x_origin, minor_edge_slope;
  logic [31:0] y_start, y_step, line_count;
  logic [31:0] red_origin, green_origin, blue_origin;
  logic [31:0] red_edge_step, green_edge_step, blue_edge_step;
  logic [31:0] red_span_step, green_span_step, blue_span_step;
  logic [31:0] depth_start_integer, depth_start_fraction;
  logic [31:0] depth_edge_step_integer, depth_edge_step_fraction;
  logic [31:0] depth_span_step_integer, depth_span_step_fraction;
  logic [31:0] scan_convert_settings, render_word;
  logic [31:0] resume_count;
  logic resume_pending;

  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire wr_fire = aw_held && w_held && !BVALID_O;
  wire [31:0] wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  wire wr_known = (aw_addr <= OFS_STATUS) && (aw_addr[1:0] == 2'b00);
  wire render_hit = wr_fire && aw_addr == OFS_RENDER;
  wire resume_hit = wr_fire && aw_addr == OFS_RESUME;

  // bus write channels: address and data taken in either order
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      BVALID_O <= 1'b0;
      BRESP_O <= RESP_OKAY;
      {AWREADY_O, WREADY_O} <= 2'b11;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_held <= 1'b1;
        AWREADY_O <= 1'b0;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_held <= 1'b1;
        WREADY_O <= 1'b0;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        {AWREADY_O, WREADY_O} <= 2'b11;
        BVALID_O <= 1'b1;
        BRESP_O <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end


  // stored values; no documented reset, so all start at zero
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      {main_edge_x_origin, main_edge_slope, minor_edge_x_origin, minor_edge_slope} <= '0;
      {y_start, y_step, line_count} <= '0;
      {red_origin, green_origin, blue_origin} <= '0;
      {red_edge_step, green_edge_step, blue_edge_step} <= '0;
      {red_span_step, green_span_step, blue_span_step} <= '0;
      {depth_start_integer, depth_start_fraction} <= '0;
      {depth_edge_step_integer, depth_edge_step_fraction} <= '0;
      {depth_span_step_integer, depth_span_step_fraction} <= '0;
      scan_convert_settings <= SETTINGS_RESET;
      render_word <= '0;
      resume_count <= '0;
    end else if (wr_fire) begin
      case (aw_addr)
        OFS_MAIN_X: main_edge_x_origin <= merge(main_edge_x_origin, w_data, wr_mask);
        OFS_MAIN_SLOPE: main_edge_slope <= merge(main_edge_slope, w_data, wr_mask);
        OFS_MINOR_X: minor_edge_x_origin <= merge(minor_edge_x_origin, w_data, wr_mask);
        OFS_MINOR_SLOPE: minor_edge_slope <= merge(minor_edge_slope, w_data, wr_mask);
        OFS_Y_START: y_start <= merge(y_start, w_data, wr_mask);
        OFS_Y_STEP: y_step <= merge(y_step, w_data, wr_mask);
        OFS_LINE_COUNT: line_count <= merge(line_count, w_data, wr_mask);
        OFS_RED_ORIGIN: red_origin <= merge(red_origin, w_data, wr_mask);
        OFS_GREEN_ORIGIN: green_origin <= merge(green_origin, w_data, wr_mask);
        OFS_BLUE_ORIGIN: blue_origin <= merge(blue_origin, w_data, wr_mask);
        OFS_RED_EDGE: red_edge_step <= merge(red_edge_step, w_data, wr_mask);
        OFS_GREEN_EDGE: green_edge_step <= merge(green_edge_step, w_data, wr_mask);
        OFS_BLUE_EDGE: blue_edge_step <= merge(blue_edge_step, w_data, wr_mask);
        OFS_RED_SPAN: red_span_step <= merge(red_span_step, w_data, wr_mask);
        OFS_GREEN_SPAN: green_span_step <= merge(green_span_step, w_data, wr_mask);
        OFS_BLUE_SPAN: blue_span_step <= merge(blue_span_step, w_data, wr_mask);
        OFS_Z_START_INT: depth_start_integer <= merge(depth_start_integer, w_data, wr_mask);
        OFS_Z_START_FRAC: depth_start_fraction <= merge(depth_start_fraction, w_data, wr_mask);
        OFS_Z_EDGE_INT:
          depth_edge_step_integer <= merge(depth_edge_step_integer, w_data, wr_mask);
        OFS_Z_EDGE_FRAC:
          depth_edge_step_fraction <= merge(depth_edge_step_fraction, w_data, wr_mask);
        OFS_Z_SPAN_INT:
          depth_span_step_integer <= merge(depth_span_step_integer, w_data, wr_mask);
        OFS_Z_SPAN_FRAC:
          depth_span_step_fraction <= merge(depth_span_step_fraction, w_data, wr_mask);
        OFS_SETTINGS: scan_convert_settings <= merge(scan_convert_settings, w_data, wr_mask);
        OFS_RENDER: render_word <= merge(render_word, w_data, wr_mask);
        OFS_RESUME: resume_count <= merge(resume_count, w_data, wr_mask);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // walker
  // ----------------------------------------------------------------
  walk_state_type state, next_state;
  logic [31:0] main_x, minor_x, cur_x, cur_y, lines_left;
  logic correct, lower_half;
  wire walk_left = $signed(minor_x) < $signed(main_x);
  wire span_done = walk_left ? ($signed(cur_x) <= $signed(minor_x))
                             : ($signed(cur_x) >= $signed(minor_x));
  wire emit = (state == ST_SPAN) && !span_done && (!FRAG_VALID_O || FRAG_READY_I);
  wire launch = (state == ST_IDLE) && render_hit;
  wire line_adv = (state == ST_SPAN) && span_done && !FRAG_VALID_O;
  wire knee_go = (state == ST_KNEE) && resume_pending;
  wire span_start = launch || (state == ST_STEP) || knee_go;
  wire new_correct = w_data[RENDER_SUBPIX_BIT];
  wire corr_now = launch ? new_correct : correct;
  wire step_gate = state == ST_STEP;

  // centre-sample the first fragment of each stepped span; the launch span starts at main_edge_x_origin
  wire [31:0] main_next = main_x + main_edge_slope;
  wire [31:0] x_seed = corr_now ? main_next + HALF_PIXEL : main_next;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (render_hit) next_state = ST_SPAN;
      ST_SPAN: if (line_adv) next_state = (lines_left > 32'h1) ? ST_STEP :
                                          lower_half ? ST_IDLE : ST_KNEE;
      ST_STEP: next_state = ST_SPAN;
      ST_KNEE: if (knee_go) next_state = ST_SPAN;
      default: next_state = ST_IDLE;
    endcase
  end

  // a resume written while spans still run waits here; set wins over clear
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) resume_pending <= 1'b0;
    else if (resume_hit) resume_pending <= 1'b1;
    else if (knee_go || launch) resume_pending <= 1'b0;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= ST_IDLE;
      {main_x, minor_x, cur_x, cur_y, lines_left} <= '0;
      {correct, lower_half} <= 2'b00;
    end else begin
      state <= next_state;
      if (launch) begin
        main_x <= main_edge_x_origin;
        minor_x <= minor_edge_x_origin;
        cur_x <= main_edge_x_origin;
        cur_y <= y_start;
        lines_left <= line_count;
        correct <= new_correct;
        lower_half <= 1'b0;
      end else if (knee_go) begin
        main_x <= main_next;
        lower_half <= 1'b1;
        minor_x <= minor_edge_x_origin;
        cur_y <= cur_y + y_step;
        lines_left <= resume_count;
      end else if (line_adv) begin
        lines_left <= lines_left - 32'h1;
      end else if (step_gate) begin
        main_x <= main_next;
        minor_x <= minor_x + minor_edge_slope;
        cur_y <= cur_y + y_step;
      end
      if (launch || step_gate || knee_go) cur_x <= launch ? main_edge_x_origin : x_seed;
      else if (emit) cur_x <= walk_left ? cur_x - {15'h0000, 1'b1, 16'h0000}
                                        : cur_x + {15'h0000, 1'b1, 16'h0000};
    end
  end

  // ----------------------------------------------------------------
  // interpolators: colour lanes and one depth lane
  // ----------------------------------------------------------------
  wire [NUM_CH*Z_W-1:0] lane_origin = {
    {{(Z_W-COLOR_W){red_origin[COLOR_W-1]}}, red_origin[COLOR_W-1:0]},
    {{(Z_W-COLOR_W){green_origin[COLOR_W-1]}}, green_origin[COLOR_W-1:0]},
    {{(Z_W-COLOR_W){blue_origin[COLOR_W-1]}}, blue_origin[COLOR_W-1:0]},
    {depth_start_integer[15:0], depth_start_fraction[31:0]}};
  wire [NUM_CH*Z_W-1:0] lane_edge = {
    {{(Z_W-COLOR_W){red_edge_step[COLOR_W-1]}}, red_edge_step[COLOR_W-1:0]},
    {{(Z_W-COLOR_W){green_edge_step[COLOR_W-1]}}, green_edge_step[COLOR_W-1:0]},
    {{(Z_W-COLOR_W){blue_edge_step[COLOR_W-1]}}, blue_edge_step[COLOR_W-1:0]},
    {depth_edge_step_integer[15:0], depth_edge_step_fraction[31:Z_FRAC_W],
     Z_FRAC_ZERO}};
  wire [NUM_CH*Z_W-1:0] lane_span = {
    {{(Z_W-COLOR_W){red_span_step[COLOR_W-1]}}, red_span_step[COLOR_W-1:0]},
    {{(Z_W-COLOR_W){green_span_step[COLOR_W-1]}}, green_span_step[COLOR_W-1:0]},
    {{(Z_W-COLOR_W){blue_span_step[COLOR_W-1]}}, blue_span_step[COLOR_W-1:0]},
    {depth_span_step_integer[15:0], depth_span_step_fraction[31:Z_FRAC_W], Z_FRAC_ZERO}};
  wire [NUM_CH*Z_W-1:0] lane_value;

  // lanes are loaded only at render, so they carry on over the knee
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_lane
      interp_lane #(.W(Z_W)) u_lane (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .load_i(launch),
        .origin_i(lane_origin[g*Z_W +: Z_W]),
        .edge_step_i(lane_edge[g*Z_W +: Z_W]),
        .span_step_i(lane_span[g*Z_W +: Z_W]),
        .correct_i(corr_now),
        .span_start_i(span_start),
        .frag_step_i(emit),
        .line_step_i(step_gate || knee_go),
        .value_o(lane_value[g*Z_W +: Z_W])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // fragment output and register reads
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      FRAG_VALID_O <= 1'b0;
      FRAG_O <= '0;
      BUSY_O <= 1'b0;
    end else begin
      BUSY_O <= next_state != ST_IDLE;
      if (emit) begin
        FRAG_VALID_O <= 1'b1;
        FRAG_O.x <= cur_x[31:X_FRAC_W];
        FRAG_O.y <= cur_y[31:X_FRAC_W];
        FRAG_O.red <= lane_value[3*Z_W +: COLOR_W];
        FRAG_O.green <= lane_value[2*Z_W +: COLOR_W];
        FRAG_O.blue <= lane_value[1*Z_W +: COLOR_W];
        FRAG_O.depth <= lane_value[Z_W-1 -: 32];
      end else if (FRAG_READY_I) begin
        FRAG_VALID_O <= 1'b0;
      end
    end
  end

  wire [31:0] status_word = {28'h0000000, resume_pending, correct, state};
  wire [31:0] rd_word =
    (ARADDR_I == OFS_SETTINGS) ? scan_convert_settings :
    (ARADDR_I == OFS_RENDER) ? render_word :
    (ARADDR_I == OFS_LINE_COUNT) ? line_count :
    (ARADDR_I == OFS_Z_START_INT) ? depth_start_integer :
    (ARADDR_I == OFS_Z_START_FRAC) ? depth_start_fraction :
    (ARADDR_I == OFS_STATUS) ? status_word : 32'h0000_0000;
  wire rd_known = (ARADDR_I <= OFS_STATUS) && (ARADDR_I[1:0] == 2'b00);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
      RDATA_O <= '0;
      RRESP_O <= RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      ARREADY_O <= 1'b0;
      RDATA_O <= rd_word;
      RRESP_O <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end


endmodule : tri_walk

//--- core/tri_walk_pkg.sv
// constants, register map and carrier types of the triangle edge walker
package tri_walk_pkg;

  // ----------------------------------------------------------------
  // register byte offsets (none given, all chosen here)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_X = 8'h00;
  localparam logic [7:0] OFS_MAIN_SLOPE = 8'h04;
  localparam logic [7:0] OFS_MINOR_X = 8'h08;
  localparam logic [7:0] OFS_MINOR_SLOPE = 8'h0C;
  localparam logic [7:0] OFS_Y_START = 8'h10;
  localparam logic [7:0] OFS_Y_STEP = 8'h14;
  localparam logic [7:0] OFS_LINE_COUNT = 8'h18;
  localparam logic [7:0] OFS_RED_ORIGIN = 8'h1C;
  localparam logic [7:0] OFS_GREEN_ORIGIN = 8'h20;
  localparam logic [7:0] OFS_BLUE_ORIGIN = 8'h24;
  localparam logic [7:0] OFS_RED_EDGE = 8'h28;
  localparam logic [7:0] OFS_GREEN_EDGE = 8'h2C;
  localparam logic [7:0] OFS_BLUE_EDGE = 8'h30;
  localparam logic [7:0] OFS_RED_SPAN = 8'h34;
  localparam logic [7:0] OFS_GREEN_SPAN = 8'h38;
  localparam logic [7:0] OFS_BLUE_SPAN = 8'h3C;
  localparam logic [7:0] OFS_Z_START_INT = 8'h40;
  localparam logic [7:0] OFS_Z_START_FRAC = 8'h44;
  localparam logic [7:0] OFS_Z_EDGE_INT = 8'h48;
  localparam logic [7:0] OFS_Z_EDGE_FRAC = 8'h4C;
  localparam logic [7:0] OFS_Z_SPAN_INT = 8'h50;
  localparam logic [7:0] OFS_Z_SPAN_FRAC = 8'h54;
  localparam logic [7:0] OFS_SETTINGS = 8'h58;
  localparam logic [7:0] OFS_RENDER = 8'h5C;
  localparam logic [7:0] OFS_RESUME = 8'h60;
  localparam logic [7:0] OFS_STATUS = 8'h64;

  // ----------------------------------------------------------------
  // formats and fields
  // ----------------------------------------------------------------
  localparam int COLOR_W = 24;
  localparam int Z_FRAC_W = 16;
  localparam int Z_W = 48;
  localparam int X_FRAC_W = 16;
  localparam int RENDER_SUBPIX_BIT = 0;
  localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
  localparam logic [15:0] Z_FRAC_ZERO = 16'h0000;
  localparam logic [31:0] HALF_PIXEL = 32'h0000_8000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int NUM_CH = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SPAN = 2'b01,
    ST_STEP = 2'b10,
    ST_KNEE = 2'b11
  } walk_state_type;

  // one emitted fragment
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [23:0] red;
    logic [23:0] green;
    logic [23:0] blue;
    logic [31:0] depth;
  } frag_type;

endpackage : tri_walk_pkg

//--- sim/tb_top.sv
// self-checking bench of the triangle edge walker
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb_top import tri_walk_pkg::*;;
  logic CLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic [7:0] AWADDR_I = 8'h00;
  logic AWVALID_I = 1'b0;
  logic [31:0] WDATA_I = 32'h0000_0000;
  logic WVALID_I = 1'b0;
  logic BREADY_I = 1'b0;
  logic [7:0] ARADDR_I = 8'h00;
  logic ARVALID_I = 1'b0;
  logic RREADY_I = 1'b0;
  logic FRAG_READY_I = 1'b1;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, FRAG_VALID_O, BUSY_O;
  logic [1:0] BRESP_O, RRESP_O;
  logic [31:0] RDATA_O;
  frag_type FRAG_O;
  frag_type frags[$];
  int err_count = 0;
  int checked = 0;
  logic [31:0] rdat;

  tri_walk dut_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(4'hF), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .FRAG_VALID_O(FRAG_VALID_O),
    .FRAG_O(FRAG_O), .FRAG_READY_I(FRAG_READY_I), .BUSY_O(BUSY_O));

  always #10 CLK_I = ~CLK_I;
  // sampled at the falling edge: the handshake lands at the next rising edge
  always @(negedge CLK_I) begin
    if (RSTN_I && FRAG_VALID_O && FRAG_READY_I) frags.push_back(FRAG_O);
  end
  // ----------------------------------------------------------------
  // bus and wait helpers
  // ----------------------------------------------------------------
  task automatic give_up();
    err_count++;
    $display("BAD %0t wait ran out", $time);
    print_verdict();
  endtask : give_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rsp;
    b = 1'b0;
    rsp = 2'b11;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    for (int n = 0; n < 64 && !b; n++) begin
      @(negedge CLK_I);
      aw = AWVALID_I && AWREADY_O;
      w = WVALID_I && WREADY_O;
      b = BVALID_O;
      rsp = BRESP_O;
      @(posedge CLK_I);
      if (aw) AWVALID_I <= 1'b0;
      if (w) WVALID_I <= 1'b0;
    end
    BREADY_I <= 1'b0;
    if (!b) give_up();
    `CHK(rsp, er)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ar, r;
    logic [1:0] rsp;
    r = 1'b0;
    rsp = 2'b11;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    for (int n = 0; n < 64 && !r; n++) begin
      @(negedge CLK_I);
      ar = ARVALID_I && ARREADY_O;
      r = RVALID_O;
      rsp = RRESP_O;
      d = RDATA_O;
      @(posedge CLK_I);
      if (ar) ARVALID_I <= 1'b0;
    end
    RREADY_I <= 1'b0;
    if (!r) give_up();
    `CHK(rsp, er)
  endtask : rd
  task automatic wait_frags(input int n);
    for (int i = 0; i < 3000 && frags.size() < n; i++) @(negedge CLK_I);
    if (frags.size() < n) give_up();
  endtask : wait_frags
  task automatic wait_idle();
    for (int i = 0; i < 3000 && BUSY_O !== 1'b0; i++) @(negedge CLK_I);
    if (BUSY_O !== 1'b0) give_up();
  endtask : wait_idle
  task automatic load_tri(input logic [31:0] mx, mn, ys, dy, cnt);
    wr(OFS_MAIN_X, mx, RESP_OKAY);
    wr(OFS_MAIN_SLOPE, 32'h0000_0000, RESP_OKAY);
    wr(OFS_MINOR_X, mn, RESP_OKAY);
    wr(OFS_MINOR_SLOPE, 32'h0000_0000, RESP_OKAY);
    wr(OFS_Y_START, ys, RESP_OKAY);
    wr(OFS_Y_STEP, dy, RESP_OKAY);
    wr(OFS_LINE_COUNT, cnt, RESP_OKAY);
  endtask : load_tri
  task automatic chk_frag(input int i, input logic [15:0] x, y, input logic [23:0] r,
                          input logic [31:0] z);
    `CHK(frags[i].x, x)
    `CHK(frags[i].y, y)
    `CHK(frags[i].red, r)
    `CHK(frags[i].depth, z)
  endtask : chk_frag
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(OFS_SETTINGS, RESP_OKAY, rdat);
    `CHK(rdat, SETTINGS_RESET)
    wr(OFS_SETTINGS, 32'h0000_005A, RESP_OKAY);
    wr(OFS_LINE_COUNT, 32'h0000_0007, RESP_OKAY);
    wr(8'h1A, 32'h0000_00FF, RESP_SLVERR);
    rd(OFS_LINE_COUNT, RESP_OKAY, rdat);
    `CHK(rdat, 32'h0000_0007)
    wr(8'h80, 32'h0000_0001, RESP_SLVERR);
    rd(8'h80, RESP_SLVERR, rdat);
    `CHK(rdat, 32'h0000_0000)
    rd(OFS_RED_ORIGIN, RESP_OKAY, rdat);
    `CHK(rdat, 32'h0000_0000)
    wr(OFS_Z_START_INT, 32'h0000_0005, RESP_OKAY);
    wr(OFS_Z_START_FRAC, 32'h8000_0000, RESP_OKAY);
    rd(OFS_Z_START_INT, RESP_OKAY, rdat);
    `CHK(rdat, 32'h0000_0005)
    rd(OFS_Z_START_FRAC, RESP_OKAY, rdat);
    `CHK(rdat, 32'h8000_0000)
  endtask : t_regs
  task automatic t_walk();
    wr(OFS_RED_ORIGIN, 32'h0010_0000, RESP_OKAY);
    wr(OFS_RED_EDGE, 32'h0000_1000, RESP_OKAY);
    wr(OFS_RED_SPAN, 32'h0000_0100, RESP_OKAY);
    wr(OFS_GREEN_ORIGIN, 32'h00FF_FF00, RESP_OKAY);
    wr(OFS_GREEN_SPAN, 32'h00FF_FFFF, RESP_OKAY);
    wr(OFS_Z_EDGE_FRAC, 32'h0100_0000, RESP_OKAY);
    wr(OFS_Z_SPAN_INT, 32'h0000_0001, RESP_OKAY);
    load_tri(32'h000A_0000, 32'h000E_0000, 32'h0014_0000, 32'h0001_0000, 32'h2);
    wr(OFS_RENDER, 32'h0000_0000, RESP_OKAY);
    rd(OFS_STATUS, RESP_OKAY, rdat);
    `CHK(rdat[2], 1'b0)
    wait_frags(8);
    repeat (20) @(negedge CLK_I);
    `CHK(BUSY_O, 1'b1)
    `CHK(frags.size(), 8)
    chk_frag(0, 16'd10, 16'd20, 24'h10_0000, 32'h0005_8000);
    chk_frag(1, 16'd11, 16'd20, 24'h10_0100, 32'h0006_8000);
    chk_frag(4, 16'd10, 16'd21, 24'h10_1000, 32'h0005_8100);
    `CHK(frags[1].green, 24'hFF_FEFF)
    wr(OFS_MINOR_X, 32'h000C_0000, RESP_OKAY);
    wr(OFS_RESUME, 32'h0000_0001, RESP_OKAY);
    wait_frags(10);
    wait_idle();
    `CHK(frags.size(), 10)
    chk_frag(8, 16'd10, 16'd22, 24'h10_2000, 32'h0005_8200);
  endtask : t_walk
  task automatic t_reverse();
    frags.delete();
    load_tri(32'h000E_0000, 32'h000A_0000, 32'h0014_0000, 32'hFFFF_0000, 32'h2);
    FRAG_READY_I <= 1'b0;
    wr(OFS_RENDER, 32'h0000_0001, RESP_OKAY);
    repeat (8) @(posedge CLK_I);
    rd(OFS_STATUS, RESP_OKAY, rdat);
    `CHK(rdat[2], 1'b1)
    FRAG_READY_I <= 1'b1;
    wr(OFS_MINOR_X, 32'h000B_0000, RESP_OKAY);
    wr(OFS_RESUME, 32'h0000_0001, RESP_OKAY);
    wait_idle();
    `CHK(frags[0].y, 16'd20)
    `CHK(frags[1].x, frags[0].x - 16'h1)
    `CHK(frags[0].red, 24'h10_0080)
    for (int i = 0; i < frags.size() - 1 && frags[i].y == 16'd20; i++) rdat = i + 1;
    `CHK(frags[rdat].y, 16'd19)
    rd(OFS_SETTINGS, RESP_OKAY, rdat);
    `CHK(rdat, 32'h0000_005A)
  endtask : t_reverse
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (16) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    t_regs();
    t_walk();
    t_reverse();
    print_verdict();
  end
endmodule : tb_top

//--- sim/tri_walk_sva.sv
// port-level assertions for the triangle edge walker
`timescale 1ns/1ps
module tri_walk_sva
  import tri_walk_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic [1:0] BRESP_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic FRAG_VALID_O,
  input wire frag_type FRAG_O,
  input wire logic FRAG_READY_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  property p_b_hold;
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold;
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_b_answer;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_bad_rd;
    ARVALID_I && ARREADY_O && ARADDR_I > OFS_STATUS
    |=> RVALID_O && RRESP_O == RESP_SLVERR && RDATA_O == 32'h0000_0000;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
  property p_bad_wr;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O && AWADDR_I[1:0] != 2'b00
    |-> ##2 BVALID_O && BRESP_O == RESP_SLVERR;
  endproperty
  a_bad_wr: assert property (p_bad_wr) else $error("misaligned write not refused");
  property p_ok_rd;
    ARVALID_I && ARREADY_O && ARADDR_I <= OFS_STATUS && ARADDR_I[1:0] == 2'b00
    |=> RVALID_O && RRESP_O == RESP_OKAY;
  endproperty
  a_ok_rd: assert property (p_ok_rd) else $error("mapped read refused");
  // ----------------------------------------------------------------
  // fragment stream
  // ----------------------------------------------------------------
  property p_frag_hold;
    FRAG_VALID_O && !FRAG_READY_I |=> FRAG_VALID_O && $stable(FRAG_O);
  endproperty
  a_frag_hold: assert property (p_frag_hold) else $error("fragment changed in stall");
  property p_x_step;
    (FRAG_VALID_O && FRAG_READY_I) ##1 (FRAG_VALID_O && FRAG_O.y == $past(FRAG_O.y))
    |-> (FRAG_O.x == $past(FRAG_O.x) + 16'h1) || (FRAG_O.x == $past(FRAG_O.x) - 16'h1);
  endproperty
  a_x_step: assert property (p_x_step) else $error("span step not one pixel");
  c_write: cover property (BVALID_O && BREADY_I);
  c_frag: cover property (FRAG_VALID_O && FRAG_READY_I);
  c_stall: cover property (FRAG_VALID_O && !FRAG_READY_I);
endmodule : tri_walk_sva

bind tri_walk tri_walk_sva sva_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .AWADDR_I(AWADDR_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
  .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .FRAG_VALID_O(FRAG_VALID_O), .FRAG_O(FRAG_O),
  .FRAG_READY_I(FRAG_READY_I));
